// ### inc/tmr8_pkg.sv
// constants shared by the 8-bit timer/counter block
`default_nettype none
package tmr8_pkg;
  localparam logic [7:0] TMR8_BOTTOM = 8'h00;
  localparam logic [7:0] TMR8_MAX = 8'hFF;
  // counting sequence codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE = 2'h1;
  localparam logic [1:0] MODE_CTC = 2'h2;
  localparam logic [1:0] MODE_FAST = 2'h3;
  // output action codes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  // register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_COMPARE = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // control register fields
  localparam int CTRL_W = 10;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_COM_LSB = 2;
  localparam int CTRL_CS_LSB = 4;
  localparam int CTRL_DDR_BIT = 8;
  localparam int CTRL_PORT_BIT = 9;
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COMPARE_RST = 8'h00;
  // flag register fields
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_BIT = 1;
  // prescaler and bus response codes
  localparam int PRE_W = 10;
  localparam logic [9:0] PRE_RST = 10'h000;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### inc/tmr8_if.sv
// signals between the register side, the counter and the waveform unit
`timescale 1ns/1ns
`default_nettype none
interface tmr8_if;
  logic tick;
  logic [1:0] mode;
  logic [1:0] com;
  logic load;
  logic [7:0] load_val;
  logic [7:0] ocr_buf;
  logic [7:0] count;
  logic down;
  logic [7:0] ocr;
  logic match;
  logic ovf;
  logic top_hit;
  logic bottom_hit;
  logic wave;
  modport top (output tick, mode, com, load, load_val, ocr_buf,
    input count, down, match, ovf, wave);
  modport ctr (input tick, mode, load, load_val, ocr_buf,
    output count, down, ocr, match, ovf, top_hit, bottom_hit);
  modport wav (input tick, mode, com, count, down, ocr, match, top_hit,
    bottom_hit, output wave);
endinterface // tmr8_if
`default_nettype wire

// ### rtl/tmr8_counter.sv
// counting sequence, compare buffer and event pulses
`timescale 1ns/1ns
`default_nettype none
module tmr8_counter (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // block signals
  tmr8_if.ctr tb
);
  import tmr8_pkg::*;
  logic [7:0] cnt_nxt;
  logic down_nxt;
  wire at_max = (tb.count == TMR8_MAX);
  wire at_bot = (tb.count == TMR8_BOTTOM);
  wire is_phase = (tb.mode == MODE_PHASE);
  always_comb begin
    cnt_nxt = tb.count + 8'h01;
    down_nxt = 1'b0;
    unique case (tb.mode)
      MODE_NORMAL: cnt_nxt = tb.count + 8'h01;
      MODE_CTC: cnt_nxt = (tb.count == tb.ocr) ? TMR8_BOTTOM
                                                : tb.count + 8'h01;
      MODE_FAST: cnt_nxt = tb.count + 8'h01;
      MODE_PHASE: begin
        down_nxt = tb.down ? !at_bot : at_max;
        cnt_nxt = down_nxt ? tb.count - 8'h01 : tb.count + 8'h01;
      end
    endcase
  end
  assign tb.match = tb.tick && (tb.count == tb.ocr);
  assign tb.ovf = tb.tick && (is_phase ? (tb.down && cnt_nxt == TMR8_BOTTOM)
    : (tb.mode == MODE_FAST) ? (cnt_nxt == TMR8_MAX) : at_max);
  assign tb.top_hit = tb.tick && at_max && !tb.down;
  assign tb.bottom_hit = tb.tick && at_bot && tb.down;
  wire ocr_upd = tb.mode[0] ? tb.top_hit : 1'b1;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tb.count <= COUNT_RST;
      tb.down <= 1'b0;
      tb.ocr <= COMPARE_RST;
    end else begin
      if (tb.load) begin
        tb.count <= tb.load_val;
      end else if (tb.tick) begin
        tb.count <= cnt_nxt;
        tb.down <= down_nxt;
      end
      if (ocr_upd) begin
        tb.ocr <= tb.ocr_buf;
      end
    end
  end
endmodule // tmr8_counter
`default_nettype wire

// ### rtl/tmr8_wave.sv
// output compare waveform generator
`timescale 1ns/1ns
`default_nettype none
module tmr8_wave (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // block signals
  tmr8_if.wav tb
);
  import tmr8_pkg::*;
  logic wave_nxt;
  logic was_max_r;
  wire up_res = tb.com[0];
  wire pwm_on = tb.com[1];
  wire ocr_max = (tb.ocr == TMR8_MAX);
  always_comb begin
    wave_nxt = tb.wave;
    unique case (tb.mode)
      MODE_NORMAL, MODE_CTC: begin
        // toggle clear or set on match
        if (tb.match && tb.com == COM_TOGGLE) wave_nxt = !tb.wave;
        else if (tb.match && pwm_on) wave_nxt = up_res;
      end
      MODE_FAST: begin
        if (pwm_on && tb.top_hit) wave_nxt = !up_res;
        else if (pwm_on && tb.match && !ocr_max) wave_nxt = up_res;
        else if (tb.match && tb.com == COM_TOGGLE) wave_nxt = !tb.wave;
      end
      MODE_PHASE: begin
        if (pwm_on && tb.tick && ocr_max) wave_nxt = !up_res;
        else if (pwm_on && tb.tick && tb.ocr == TMR8_BOTTOM)
          wave_nxt = up_res;
        else if (pwm_on && tb.match)
          wave_nxt = tb.down ? !up_res : up_res;
        else if (pwm_on && tb.bottom_hit && was_max_r) wave_nxt = up_res;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tb.wave <= 1'b0;
      was_max_r <= 1'b0;
    end else begin
      tb.wave <= wave_nxt;
      // old compare sampled before the top update lands
      if (tb.top_hit) was_max_r <= ocr_max;
    end
  end
endmodule // tmr8_wave
`default_nettype wire

// ### rtl/tmr8_top.sv
// 8-bit timer/counter with one compare output, AXI4-Lite registers
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module tmr8_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [tmr8_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [tmr8_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt service acknowledges from the vector logic
  input wire logic ovf_service_ack,
  input wire logic cmp_service_ack,
  // compare output pin
  output logic wave_pin_out,
  output logic wave_pin_oe_n
);
  import tmr8_pkg::*;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = new_v[8*i +: 8];
    end
    return res;
  endfunction

  function automatic logic [PRE_W-1:0] pre_mask(input logic [2:0] sel);
    logic [PRE_W-1:0] m;
    m = 10'h000;
    unique case (sel)
      3'h0: m = 10'h000;
      3'h1: m = 10'h000;
      3'h2: m = 10'h007;
      3'h3: m = 10'h01F;
      3'h4: m = 10'h03F;
      3'h5: m = 10'h07F;
      3'h6: m = 10'h0FF;
      3'h7: m = 10'h3FF;
    endcase
    return m;
  endfunction

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    return (a == OFS_CTRL) || (a == OFS_COUNT) || (a == OFS_COMPARE) ||
      (a == OFS_FLAGS) || (a == OFS_STATUS);
  endfunction

  // write channel state
  logic aw_got_r;
  logic aw_got_nxt;
  logic [ADDR_W-1:0] aw_addr_r;
  logic w_got_r;
  logic w_got_nxt;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  // read channel state
  logic arready_r;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  // block registers
  logic [CTRL_W-1:0] ctrl_r;
  logic [7:0] ocr_buf_r;
  logic ovf_flag_r;
  logic ovf_flag_nxt;
  logic cmp_flag_r;
  logic cmp_flag_nxt;
  logic [PRE_W-1:0] pre_cnt_r;
  logic pin_out_r;
  logic pin_oe_n_r;

  tmr8_if tb ();

  // handshake decode
  wire aw_take = s_axi_awvalid && awready_r;
  wire w_take = s_axi_wvalid && wready_r;
  wire wr_do = aw_got_r && w_got_r && !bvalid_r;
  wire ar_take = s_axi_arvalid && arready_r;

  // register write decode
  wire wr_hit = addr_hit(aw_addr_r);
  wire wr_ctrl = wr_do && (aw_addr_r == OFS_CTRL);
  wire wr_count = wr_do && (aw_addr_r == OFS_COUNT) && w_strb_r[0];
  wire wr_compare = wr_do && (aw_addr_r == OFS_COMPARE);
  wire wr_flags = wr_do && (aw_addr_r == OFS_FLAGS) && w_strb_r[0];
  wire [31:0] ctrl_merged = merge_bytes({22'h000000, ctrl_r}, w_data_r,
    w_strb_r);
  wire [31:0] ocr_merged = merge_bytes({24'h000000, ocr_buf_r}, w_data_r,
    w_strb_r);

  // control fields
  wire [1:0] mode_sel = ctrl_r[CTRL_MODE_LSB +: 2];
  wire [1:0] com_sel = ctrl_r[CTRL_COM_LSB +: 2];
  wire [2:0] clk_sel = ctrl_r[CTRL_CS_LSB +: 3];
  wire dir_out = ctrl_r[CTRL_DDR_BIT];
  wire port_level = ctrl_r[CTRL_PORT_BIT];

  // prescaled timer tick, one aclk wide
  wire [PRE_W-1:0] cur_mask = pre_mask(clk_sel);
  wire timer_tick = (clk_sel != CS_STOP) &&
    ((pre_cnt_r & cur_mask) == cur_mask);

  // flag clear sources
  wire ovf_clr = (wr_flags && w_data_r[FLAG_OVF_BIT]) || ovf_service_ack;
  wire cmp_clr = (wr_flags && w_data_r[FLAG_CMP_BIT]) || cmp_service_ack;

  // read mux
  wire rd_hit = addr_hit(s_axi_araddr);
  wire [31:0] rd_data =
    (s_axi_araddr == OFS_CTRL) ? {22'h000000, ctrl_r} :
    (s_axi_araddr == OFS_COUNT) ? {24'h000000, tb.count} :
    (s_axi_araddr == OFS_COMPARE) ? {24'h000000, ocr_buf_r} :
    (s_axi_araddr == OFS_FLAGS) ? {30'h00000000, cmp_flag_r, ovf_flag_r} :
    (s_axi_araddr == OFS_STATUS) ? {30'h00000000, tb.down, tb.wave} :
    32'h00000000;

  // drive the shared block signals
  assign tb.tick = timer_tick;
  assign tb.mode = mode_sel;
  assign tb.com = com_sel;
  assign tb.load = wr_count;
  assign tb.load_val = w_data_r[7:0];
  assign tb.ocr_buf = ocr_buf_r;

  // next-state terms for the bus
  assign aw_got_nxt = wr_do ? 1'b0 : (aw_got_r || aw_take);
  assign w_got_nxt = wr_do ? 1'b0 : (w_got_r || w_take);
  assign bvalid_nxt = wr_do ? 1'b1 : (bvalid_r && !s_axi_bready);
  assign rvalid_nxt = ar_take ? 1'b1 : (rvalid_r && !s_axi_rready);

  assign ovf_flag_nxt = tb.ovf || (ovf_flag_r && !ovf_clr);
  assign cmp_flag_nxt = tb.match || (cmp_flag_r && !cmp_clr);

  tmr8_counter u_counter (
    .aclk (aclk),
    .aresetn (aresetn),
    .tb (tb.ctr)
  );

  tmr8_wave u_wave (
    .aclk (aclk),
    .aresetn (aresetn),
    .tb (tb.wav)
  );

  // write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      if (aw_take) aw_addr_r <= s_axi_awaddr;
      if (w_take) w_data_r <= s_axi_wdata;
      if (w_take) w_strb_r <= s_axi_wstrb;
    end
  end

  // ready stays low while a write is parked or its answer pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      awready_r <= !aw_got_nxt && !bvalid_nxt;
      wready_r <= !w_got_nxt && !bvalid_nxt;
      bvalid_r <= bvalid_nxt;
      if (wr_do) bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // read channel, one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else begin
      arready_r <= !rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_take) rdata_r <= rd_data;
      if (ar_take) rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // control and compare buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      ocr_buf_r <= COMPARE_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= ctrl_merged[CTRL_W-1:0];
      if (wr_compare) ocr_buf_r <= ocr_merged[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_flag_r <= 1'b0;
      cmp_flag_r <= 1'b0;
    end else begin
      ovf_flag_r <= ovf_flag_nxt;
      cmp_flag_r <= cmp_flag_nxt;
    end
  end

  // free-running prescaler; divided ticks are phase-locked to it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_r <= PRE_RST;
    end else begin
      pre_cnt_r <= pre_cnt_r + 10'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_r <= 1'b0;
      pin_oe_n_r <= 1'b1;
    end else begin
      pin_out_r <= (com_sel != COM_OFF) ? tb.wave : port_level;
      pin_oe_n_r <= !dir_out;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign wave_pin_out = pin_out_r;
  assign wave_pin_oe_n = pin_oe_n_r;
endmodule // tmr8_top
`default_nettype wire

// ### testbench/tmr8_assertions.sv
// port-level checks for the timer block and its register bus
`timescale 1ns/1ns
`default_nettype none
module tmr8_assertions (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tmr8_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pin
  input wire logic wave_pin_out,
  input wire logic wave_pin_oe_n
);
  import tmr8_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_pair;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_resp_time: assert property (wr_pair |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  a_rd_resp_time: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data not on time");
  a_rd_unmapped_err: assert property ((s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > OFS_STATUS) |=> s_axi_rresp == RESP_SLVERR &&
    s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_b_hold_stable: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold_stable: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_aw_refuse_busy: assert property (wr_pair |=> !s_axi_awready [*2])
    else $error("write address taken while busy");
  // arready comes back the cycle after rready meets rvalid
  a_ar_refuse_busy: assert property (rd_take |=> !s_axi_arready &&
    s_axi_rvalid)
    else $error("read address taken while busy");
  // outputs idle one cycle after reset is seen
  a_reset_idle_out: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && wave_pin_oe_n && !wave_pin_out)
    else $error("outputs not idle in reset");
  a_pin_dir_write: assert property ($changed(wave_pin_oe_n) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("pin enable moved without a write");
endmodule // tmr8_assertions
bind tmr8_top tmr8_assertions u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .wave_pin_out, .wave_pin_oe_n);
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench: register bus tasks and waveform measurements
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import tmr8_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic ovf_ack = 1'b0, cmp_ack = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin, oe_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int err_total = 0, check_count = 0;
  tmr8_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ovf_service_ack(ovf_ack),
    .cmp_service_ack(cmp_ack), .wave_pin_out(pin), .wave_pin_oe_n(oe_n));
  initial begin
    forever #2 aclk = ~aclk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // both channels offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    r = 2'h1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (aw_d && w_d && bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
      if (!aw_d && awready === 1'b1) begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_d && wready === 1'b1) begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    logic a_d;
    a_d = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (a_d && rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
      if (!a_d && arready === 1'b1) begin
        a_d = 1'b1;
        arvalid <= 1'b0;
      end
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk32(d, exp);
    chk32({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  // ctrl word: mode, action, clock select 1 or stop, direction bit
  task automatic cfg(input logic [1:0] m, input logic [1:0] c,
      input logic [7:0] v, input logic run, input logic dir);
    logic [1:0] r;
    axi_wr(OFS_COMPARE, {24'h0, v}, r);
    axi_wr(OFS_CTRL, {23'h0, dir, 1'b0, 2'h0, run, c, m}, r);
  endtask
  task automatic wl(input logic v, output int n);
    n = 0;
    while (pin !== v && n < 1200) begin
      @(posedge aclk);
      n++;
    end
  endtask
  logic [1:0] md[13] = '{MODE_NORMAL, MODE_CTC, MODE_FAST, MODE_FAST,
    MODE_FAST, MODE_FAST, MODE_PHASE, MODE_PHASE, MODE_FAST, MODE_FAST,
    MODE_PHASE, MODE_PHASE, MODE_PHASE};
  logic [1:0] cm[13] = '{COM_TOGGLE, COM_TOGGLE, COM_CLEAR, COM_SET,
    COM_TOGGLE, COM_CLEAR, COM_CLEAR, COM_SET, COM_CLEAR, COM_SET,
    COM_CLEAR, COM_CLEAR, COM_SET};
  logic [7:0] cv[13] = '{8'h10, 8'h09, 8'h3F, 8'h3F, 8'h20, 8'h00,
    8'h40, 8'h40, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00};
  int eh[13] = '{256, 10, 64, 192, 256, 1, 128, 382, 1, 0, 0, 1, 1};
  // zero period marks a constant level
  int ep[13] = '{512, 20, 256, 256, 512, 256, 510, 510, 0, 0, 0, 0, 0};
  initial begin
    #400000;
    err_total++;
    end_sim();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int h, l;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(OFS_CTRL, 32'h0);
    rd_chk(OFS_COMPARE, 32'h0);
    rd_chk(OFS_COUNT, 32'h0);
    axi_rd(8'h40, d, r);
    chk32({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_wr(8'h40, 32'h1, r);
    chk32({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_wr(OFS_COUNT, 32'h5A, r);
    rd_chk(OFS_COUNT, 32'h5A);
    cfg(MODE_NORMAL, COM_OFF, 8'h10, 1'b1, 1'b0);
    repeat (600) @(posedge aclk);
    cfg(MODE_NORMAL, COM_OFF, 8'h10, 1'b0, 1'b0);
    chk32({31'h0, oe_n}, 32'h1);
    rd_chk(OFS_FLAGS, 32'h3);
    @(posedge aclk);
    ovf_ack <= 1'b1;
    @(posedge aclk);
    ovf_ack <= 1'b0;
    rd_chk(OFS_FLAGS, 32'h2);
    axi_wr(OFS_FLAGS, 32'h2, r);
    rd_chk(OFS_FLAGS, 32'h0);
    rd_chk(OFS_STATUS, 32'h0);
    for (int i = 0; i < 13; i++) begin
      cfg(md[i], cm[i], cv[i], 1'b1, 1'b1);
      repeat (600) @(posedge aclk);
      chk32({31'h0, oe_n}, 32'h0);
      if (ep[i] == 0) begin
        chk32({31'h0, pin}, eh[i]);
        wl(~pin, h);
        chk_n(h, 1200);
      end else begin
        wl(1'b0, h);
        wl(1'b1, h);
        wl(1'b0, h);
        wl(1'b1, l);
        chk_n(h, eh[i]);
        chk_n(h + l, ep[i]);
      end
    end
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
